// ==== logic/rih_top.sv ====
// Control-line handshake of the soldering robot, with APB registers
// Assumes controller lines are asynchronous and the motion core is software
`timescale 1ns/100ps
`default_nettype none
`include "rih_defs.svh"
module rih_top #(
    parameter int unsigned END_CYC = `RIH_END_CYC,
    parameter int unsigned RST_CYC = `RIH_RST_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Controller inputs
    input wire logic [6:0] prog_sel,
    input wire logic home_in,
    input wire logic start_in,
    input wire logic pstop_in,
    input wire logic reset_in,
    input wire logic [4:0] aux_in,
    input wire logic estop_loop_ok,
    // Controller outputs
    output logic ready_o,
    output logic running_o,
    output logic end_o,
    output logic error_o,
    output logic [6:0] aux_out,
    // Core controls
    output logic heater_on,
    output logic axis_move,
    output logic home_req,
    output logic irq
);
    // ----------------------------------------
    // Input synchronisation
    // ----------------------------------------
    rih_pkg::rih_in_type in_s, in_d;
    logic [16:0] in_q;

    rih_sync #(.W(17)) u_sync (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .d({prog_sel, home_in, start_in, pstop_in, reset_in, aux_in, !estop_loop_ok}),
        .q(in_q)
    );
    // Loop bit synchronised inverted, so reset reads closed and raises no false emergency
    assign in_s = in_q ^ 17'h00001;

    // ----------------------------------------
    // State
    // ----------------------------------------
    rih_pkg::rih_state_type state_r, state_nxt;
    rih_pkg::rih_wps_type wps_r, wps_nxt;
    logic [1:0] ctrl_r, ctrl_nxt;
    logic [4:0] ev_r, ev_nxt, mask_r, mask_nxt;
    logic [31:0] end_cnt_r, end_cnt_nxt, rst_cnt_r, rst_cnt_nxt;
    logic pend_r, pend_nxt, ack_r, ack_nxt, err_r, err_nxt;
    logic ready_r, ready_nxt, run_r, run_nxt, end_r, end_nxt;
    logic heat_r, heat_nxt, axis_r, axis_nxt, hreq_r, hreq_nxt;
    logic [6:0] aout_r, aout_nxt, prog_r, prog_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt, pslverr_r, pslverr_nxt, irq_r, irq_nxt;

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    logic wr, setup, hit, step_w, last_w, err_w, hdone_w, solder;
    assign setup = psel && !penable && !pready_r;
    assign wr = psel && penable && pready_r && pwrite;
    assign hit = (paddr == `RIH_ADDR_CTRL) || (paddr == `RIH_ADDR_WPS) || (paddr == `RIH_ADDR_STAT)
                 || (paddr == `RIH_ADDR_IRQ) || (paddr == `RIH_ADDR_MASK);
    // Pulse fields act only in the write cycle
    assign step_w = wr && (paddr == `RIH_ADDR_CTRL) && pwdata[`RIH_CTRL_STEP];
    assign last_w = pwdata[`RIH_CTRL_LAST];
    assign err_w = wr && (paddr == `RIH_ADDR_CTRL) && pwdata[`RIH_CTRL_ERR];
    assign hdone_w = wr && (paddr == `RIH_ADDR_CTRL) && pwdata[`RIH_CTRL_HDONE];
    assign solder = ctrl_r[0];

    // ----------------------------------------
    // Handshake control
    // ----------------------------------------
    logic start_e, home_e, rst_hit, step_go, ev_start, ev_end, ev_err, ev_estop, ev_pstop;
    assign start_e = in_s.start && !in_d.start;
    assign home_e = in_s.home && !in_d.home;
    assign step_go = (wps_r.in_sel == 3'h0) || (wps_r.in_sel > 3'h5)
                     || (in_s.aux[wps_r.in_sel - 3'h1] == wps_r.in_level);

    always_comb begin
        state_nxt = state_r;
        pend_nxt = pend_r;
        ack_nxt = ack_r && in_s.start;
        err_nxt = err_r;
        prog_nxt = prog_r;
        end_cnt_nxt = (end_cnt_r != 32'h0) ? end_cnt_r - 32'h1 : 32'h0;
        rst_cnt_nxt = in_s.rst ? ((rst_cnt_r < RST_CYC) ? rst_cnt_r + 32'h1 : rst_cnt_r) : 32'h0;
        // Short glitches on reset are ignored; one hit per pulse
        rst_hit = in_s.rst && (rst_cnt_r == RST_CYC - 32'h1);
        ev_start = 1'b0;
        ev_end = 1'b0;
        ev_err = 1'b0;
        ev_estop = 1'b0;
        ev_pstop = 1'b0;
        if (!in_s.loop_ok) begin
            // Open break contact overrides everything
            if (state_r != rih_pkg::ST_ESTOP) begin
                ev_estop = 1'b1;
            end
            state_nxt = rih_pkg::ST_ESTOP;
            pend_nxt = 1'b0;
        end else begin
            case (state_r)
                rih_pkg::ST_IDLE: begin
                    if (home_e) begin
                        state_nxt = rih_pkg::ST_HOMING;
                    end
                end
                rih_pkg::ST_HOMING: begin
                    if (hdone_w) begin
                        state_nxt = rih_pkg::ST_READY;
                        err_nxt = 1'b0;
                    end
                end
                rih_pkg::ST_READY: begin
                    if (start_e) begin
                        state_nxt = rih_pkg::ST_RUN;
                        prog_nxt = in_s.prog_sel;
                        ack_nxt = 1'b1;
                        ev_start = 1'b1;
                    end else if (home_e) begin
                        state_nxt = rih_pkg::ST_HOMING;
                    end
                end
                rih_pkg::ST_RUN: begin
                    if (in_s.pstop) begin
                        pend_nxt = 1'b1;
                    end
                    if (step_w && last_w) begin
                        state_nxt = rih_pkg::ST_READY;
                        end_cnt_nxt = END_CYC;
                        pend_nxt = 1'b0;
                        ev_end = 1'b1;
                    end else if ((pend_r || in_s.pstop) && !solder) begin
                        state_nxt = rih_pkg::ST_PSTOP;
                        pend_nxt = 1'b0;
                        ev_pstop = 1'b1;
                    end
                end
                rih_pkg::ST_PSTOP: begin
                    if (start_e) begin
                        state_nxt = rih_pkg::ST_RUN;
                        ack_nxt = 1'b1;
                        ev_start = 1'b1;
                    end
                end
                rih_pkg::ST_ERROR, rih_pkg::ST_ESTOP: begin
                    if (rst_hit) begin
                        state_nxt = rih_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_nxt = rih_pkg::ST_IDLE;
                end
            endcase
            if (err_w && state_r != rih_pkg::ST_ESTOP) begin
                state_nxt = rih_pkg::ST_ERROR;
                err_nxt = 1'b1;
                ev_err = 1'b1;
            end
        end
        ready_nxt = (state_nxt == rih_pkg::ST_READY) || ((state_nxt == rih_pkg::ST_RUN) && ack_nxt);
        run_nxt = (state_nxt == rih_pkg::ST_RUN);
        end_nxt = (end_cnt_nxt != 32'h0);
        heat_nxt = ctrl_r[1] && (state_nxt != rih_pkg::ST_ESTOP);
        // Soldering may finish under a pending stop, motion may not start
        axis_nxt = (state_nxt == rih_pkg::ST_RUN) && (solder || (step_go && !pend_nxt));
        hreq_nxt = (state_nxt == rih_pkg::ST_HOMING);
        aout_nxt = (state_nxt == rih_pkg::ST_ESTOP) ? 7'h00 : wps_r.aux_out;
    end

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    always_comb begin
        wps_nxt = wps_r;
        ctrl_nxt = ctrl_r;
        mask_nxt = mask_r;
        ev_nxt = ev_r;
        prdata_nxt = prdata_r;
        pready_nxt = setup;
        pslverr_nxt = setup && !hit;
        if (setup) begin
            case (paddr)
                `RIH_ADDR_CTRL: prdata_nxt = {26'h0, ctrl_r[1], 2'h0, ctrl_r[0], 2'h0};
                `RIH_ADDR_WPS: prdata_nxt = {21'h0, wps_r};
                `RIH_ADDR_STAT: prdata_nxt = {14'h0, in_s.loop_ok, pend_r, in_s.aux, prog_r, err_r, state_r};
                `RIH_ADDR_IRQ: prdata_nxt = {27'h0, ev_r};
                `RIH_ADDR_MASK: prdata_nxt = {27'h0, mask_r};
                default: prdata_nxt = 32'h0;
            endcase
        end
        if (wr) begin
            case (paddr)
                `RIH_ADDR_CTRL: ctrl_nxt = {pwdata[`RIH_CTRL_HEAT], pwdata[`RIH_CTRL_SOLDER]};
                `RIH_ADDR_WPS: wps_nxt = pwdata[10:0];
                `RIH_ADDR_IRQ: ev_nxt = ev_r & ~pwdata[4:0];
                `RIH_ADDR_MASK: mask_nxt = pwdata[4:0];
                default: ;
            endcase
        end
        // New events win over a clear in the same cycle
        ev_nxt = ev_nxt | {ev_pstop, ev_estop, ev_err, ev_end, ev_start};
        irq_nxt = |(ev_nxt & mask_nxt);
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_r <= rih_pkg::ST_IDLE;
            in_d <= '0;
            wps_r <= `RIH_WPS_RST;
            ctrl_r <= `RIH_CTRL_RST;
            mask_r <= `RIH_MASK_RST;
            ev_r <= 5'h00;
            end_cnt_r <= 32'h0;
            rst_cnt_r <= 32'h0;
            pend_r <= 1'b0;
            ack_r <= 1'b0;
            err_r <= 1'b0;
            prog_r <= 7'h00;
            ready_r <= 1'b0;
            run_r <= 1'b0;
            end_r <= 1'b0;
            heat_r <= 1'b0;
            axis_r <= 1'b0;
            hreq_r <= 1'b0;
            aout_r <= 7'h00;
            prdata_r <= 32'h0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            in_d <= in_s;
            wps_r <= wps_nxt;
            ctrl_r <= ctrl_nxt;
            mask_r <= mask_nxt;
            ev_r <= ev_nxt;
            end_cnt_r <= end_cnt_nxt;
            rst_cnt_r <= rst_cnt_nxt;
            pend_r <= pend_nxt;
            ack_r <= ack_nxt;
            err_r <= err_nxt;
            prog_r <= prog_nxt;
            ready_r <= ready_nxt;
            run_r <= run_nxt;
            end_r <= end_nxt;
            heat_r <= heat_nxt;
            axis_r <= axis_nxt;
            hreq_r <= hreq_nxt;
            aout_r <= aout_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign ready_o = ready_r;
    assign running_o = run_r;
    assign end_o = end_r;
    assign error_o = err_r;
    assign aux_out = aout_r;
    assign heater_on = heat_r;
    assign axis_move = axis_r;
    assign home_req = hreq_r;
    assign irq = irq_r;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    logic [31:0] end_len_r;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            end_len_r <= 32'h0;
        end else begin
            end_len_r <= end_r ? end_len_r + 32'h1 : 32'h0;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    sequence seq_take_start;
        (state_r == rih_pkg::ST_READY) && start_e && in_s.loop_ok && !err_w;
    endsequence
    sequence seq_running_acked;
        (state_r == rih_pkg::ST_RUN) && run_r && ready_r;
    endsequence

    AST_START_ACK: assert property (seq_take_start |=> seq_running_acked)
        else $error("start not acknowledged");
    AST_READY_LEVEL: assert property ((state_r == rih_pkg::ST_READY) |-> ready_r)
        else $error("ready low while launchable");
    AST_RUNNING: assert property (run_r == (state_r == rih_pkg::ST_RUN))
        else $error("running mismatch");
    AST_END_WIDTH: assert property ($fell(end_r) |-> $past(end_len_r) == END_CYC - 32'h1)
        else $error("end pulse width wrong");
    AST_PSTOP_AXIS: assert property ((state_r == rih_pkg::ST_PSTOP) |-> !axis_r)
        else $error("axis moving in partial stop");
    AST_PSTOP_SOLDER: assert property ((state_r == rih_pkg::ST_RUN) && solder && in_s.loop_ok && !err_w
        && !(step_w && last_w) |=> (state_r == rih_pkg::ST_RUN))
        else $error("stopped during soldering");
    AST_ESTOP: assert property (!in_s.loop_ok |=> (state_r == rih_pkg::ST_ESTOP) ##1 !heater_on)
        else $error("emergency not honoured");
    AST_ERR_HOLD: assert property (err_r && !hdone_w |=> err_r)
        else $error("error dropped without home");
    AST_AUXOUT: assert property ((state_r == rih_pkg::ST_RUN) && in_s.loop_ok && $stable(wps_r)
        |=> aux_out == $past(wps_r.aux_out))
        else $error("aux outputs not from work parameter set");
    AST_RST_EXIT: assert property ((state_r == rih_pkg::ST_ESTOP) && in_s.loop_ok && !rst_hit
        |=> (state_r == rih_pkg::ST_ESTOP))
        else $error("emergency left without reset");
endmodule
`default_nettype wire

// ==== logic/rih_defs.svh ====
// Constants of the robot control-line handshake block
// Assumes a 125 MHz system clock and an APB master with 8-bit addresses
`ifndef RIH_DEFS_SVH
`define RIH_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RIH_ADDR_CTRL 8'h00
`define RIH_ADDR_WPS 8'h04
`define RIH_ADDR_STAT 8'h08
`define RIH_ADDR_IRQ 8'h0c
`define RIH_ADDR_MASK 8'h10

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RIH_CTRL_STEP 0
`define RIH_CTRL_LAST 1
`define RIH_CTRL_SOLDER 2
`define RIH_CTRL_ERR 3
`define RIH_CTRL_HDONE 4
`define RIH_CTRL_HEAT 5
`define RIH_EV_START 0
`define RIH_EV_END 1
`define RIH_EV_ERR 2
`define RIH_EV_ESTOP 3
`define RIH_EV_PSTOP 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RIH_WPS_RST 11'h000
`define RIH_MASK_RST 5'h00
`define RIH_CTRL_RST 2'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define RIH_CLK_KHZ 125000
`define RIH_END_MS 100
`define RIH_RST_MS 100
`define RIH_END_CYC (`RIH_END_MS * `RIH_CLK_KHZ)
`define RIH_RST_CYC (`RIH_RST_MS * `RIH_CLK_KHZ + 1)

`endif

// ==== logic/rih_pkg.sv ====
// Types of the robot control-line handshake block
// Assumes nothing beyond the constants header
package rih_pkg;

    // Synchronised controller lines
    typedef struct packed {
        logic [6:0] prog_sel;
        logic home;
        logic start;
        logic pstop;
        logic rst;
        logic [4:0] aux;
        logic loop_ok;
    } rih_in_type;

    // One step's work parameter set
    typedef struct packed {
        logic in_level;
        logic [2:0] in_sel;
        logic [6:0] aux_out;
    } rih_wps_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_HOMING = 3'b001,
        ST_READY = 3'b010,
        ST_RUN = 3'b011,
        ST_PSTOP = 3'b100,
        ST_ERROR = 3'b101,
        ST_ESTOP = 3'b110
    } rih_state_type;

endpackage

// ==== logic/rih_sync.sv ====
// Three-stage input synchroniser with agreement filter
// Assumes inputs are asynchronous to clk_sys
`timescale 1ns/100ps
`default_nettype none
module rih_sync #(
    parameter int unsigned W = 17
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Lines
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_r, s2_r, s3_r, q_r;
    logic [W-1:0] q_nxt;

    // A bit only changes once stages two and three agree
    always_comb begin
        for (int i = 0; i < W; i++) begin
            q_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : q_r[i];
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            q_r <= '0;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q_r <= q_nxt;
        end
    end

    assign q = q_r;
endmodule
`default_nettype wire

// ==== test/rih_plc_model.sv ====
// Controller-side model: drives the robot's discrete control lines
// Assumes the bench calls its tasks just after a clk_sys edge
`timescale 1ns/100ps
`default_nettype none
module rih_plc_model (
    // Clock
    input wire logic clk_sys,
    // Lines to the robot
    output logic [6:0] prog_sel,
    output logic home_in,
    output logic start_in,
    output logic pstop_in,
    output logic reset_in,
    output logic [4:0] aux_in,
    output logic estop_loop_ok
);
    initial begin
        prog_sel = 7'h00;
        home_in = 1'b0;
        start_in = 1'b0;
        pstop_in = 1'b0;
        reset_in = 1'b0;
        aux_in = 5'h00;
        estop_loop_ok = 1'b1;
    end

    // Program number stays on the lines after start
    task automatic pulse_start(input logic [6:0] prog);
        prog_sel <= prog;
        start_in <= 1'b1;
        repeat (8) @(posedge clk_sys);
        start_in <= 1'b0;
    endtask

    task automatic pulse_home;
        home_in <= 1'b1;
        repeat (8) @(posedge clk_sys);
        home_in <= 1'b0;
    endtask

    // Pulse width must beat the device's filter
    task automatic hold_reset(input int n);
        reset_in <= 1'b1;
        repeat (n) @(posedge clk_sys);
        reset_in <= 1'b0;
    endtask

    task automatic set_lines(input logic loop, input logic ps, input logic [4:0] aux);
        estop_loop_ok <= loop;
        pstop_in <= ps;
        aux_in <= aux;
    endtask
endmodule
`default_nettype wire

// ==== test/rih_top_bench.sv ====
// Self-checking bench of the control-line handshake block
// Assumes rih_top, rih_pkg and the controller model compiled first
`timescale 1ns/100ps
`default_nettype none
`include "rih_defs.svh"
module rih_top_bench;
    localparam int END_CYC = 20;
    localparam int RST_CYC = 5;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, last_err;
    logic [6:0] prog_sel, aux_out;
    logic [4:0] aux_in;
    logic home_in, start_in, pstop_in, reset_in, estop_loop_ok;
    logic ready_o, running_o, end_o, error_o, heater_on, axis_move, home_req, irq;
    int num_errors = 0;
    int check_count = 0;
    int cnt;

    always #4 clk_sys = ~clk_sys;

    rih_top #(.END_CYC(END_CYC), .RST_CYC(RST_CYC)) DUT (.clk_sys(clk_sys), .rstn(rstn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .prog_sel(prog_sel),
        .home_in(home_in), .start_in(start_in), .pstop_in(pstop_in), .reset_in(reset_in),
        .aux_in(aux_in), .estop_loop_ok(estop_loop_ok), .ready_o(ready_o),
        .running_o(running_o), .end_o(end_o), .error_o(error_o), .aux_out(aux_out),
        .heater_on(heater_on), .axis_move(axis_move), .home_req(home_req), .irq(irq));

    rih_plc_model plc (.clk_sys(clk_sys), .prog_sel(prog_sel), .home_in(home_in),
        .start_in(start_in), .pstop_in(pstop_in), .reset_in(reset_in), .aux_in(aux_in),
        .estop_loop_ok(estop_loop_ok));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Request held until pready is sampled high; only the watchdog ends a hang
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic state_is(input logic [2:0] s);
        apb(1'b0, `RIH_ADDR_STAT, 32'h0);
        chk("state", {29'h0, s}, {29'h0, rd[2:0]});
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #200000;
        num_errors++;
        print_verdict();
    end

    initial begin
        wt(16);
        rstn <= 1'b1;
        wt(6);
        chk("outs", 32'h0, {21'h0, ready_o, running_o, end_o, error_o, aux_out});
        apb(1'b0, `RIH_ADDR_STAT, 32'h0);
        chk("stat", 32'h8, {28'h0, rd[17], rd[2:0]});
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped", 32'h1, {rd[30:0], last_err});
        $display("test reset done");
        // Power-up homing
        plc.pulse_home();
        wt(6);
        chk("home_req", 32'h1, {31'h0, home_req});
        apb(1'b1, `RIH_ADDR_CTRL, 32'h10);
        wt(2);
        chk("ready", 32'h1, {31'h0, ready_o});
        state_is(rih_pkg::ST_READY);
        $display("test home done");
        // Start, masked then unmasked interrupt
        apb(1'b1, `RIH_ADDR_WPS, 32'h55);
        plc.set_lines(1'b1, 1'b0, 5'h0a);
        plc.pulse_start(7'h63);
        chk("ready ack", 32'h1, {31'h0, ready_o});
        chk("running", 32'h1, {31'h0, running_o});
        chk("aux_out", 32'h55, {25'h0, aux_out});
        apb(1'b0, `RIH_ADDR_STAT, 32'h0);
        chk("prog", 32'h63, {25'h0, rd[10:4]});
        chk("aux_in", 32'h0a, {27'h0, rd[15:11]});
        chk("run", 32'h3, {29'h0, rd[2:0]});
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1'b1, `RIH_ADDR_MASK, 32'h1);
        wt(2);
        chk("irq", 32'h1, {31'h0, irq});
        apb(1'b1, `RIH_ADDR_IRQ, 32'h1f);
        wt(2);
        chk("irq clr", 32'h0, {31'h0, irq});
        chk("ready in run", 32'h0, {31'h0, ready_o});
        // Step waits for aux input 1 high
        apb(1'b1, `RIH_ADDR_WPS, 32'h4d5);
        wt(2);
        chk("axis wait", 32'h0, {31'h0, axis_move});
        plc.set_lines(1'b1, 1'b0, 5'h0b);
        wt(8);
        chk("axis go", 32'h1, {31'h0, axis_move});
        apb(1'b1, `RIH_ADDR_WPS, 32'h55);
        $display("test start done");
        // Partial stop during soldering
        apb(1'b1, `RIH_ADDR_CTRL, 32'h4);
        plc.set_lines(1'b1, 1'b1, 5'h0a);
        wt(8);
        state_is(rih_pkg::ST_RUN);
        chk("axis solder", 32'h1, {31'h0, axis_move});
        apb(1'b1, `RIH_ADDR_CTRL, 32'h0);
        wt(3);
        state_is(rih_pkg::ST_PSTOP);
        chk("axis", 32'h0, {31'h0, axis_move});
        chk("running", 32'h0, {31'h0, running_o});
        plc.set_lines(1'b1, 1'b0, 5'h0a);
        wt(6);
        plc.pulse_start(7'h63);
        state_is(rih_pkg::ST_RUN);
        $display("test pstop done");
        // End pulse width
        apb(1'b1, `RIH_ADDR_CTRL, 32'h3);
        cnt = 0;
        // Sample before waiting, so the cycle after the write edge counts
        for (int i = 0; i < END_CYC + 20; i++) begin
            if (end_o === 1'b1) cnt++;
            @(posedge clk_sys);
        end
        chk("end width", END_CYC, cnt);
        chk("run/rdy", 32'h1, {30'h0, running_o, ready_o});
        $display("test end done");
        // Error recovery
        apb(1'b1, `RIH_ADDR_CTRL, 32'h8);
        wt(2);
        chk("error", 32'h1, {31'h0, error_o});
        plc.hold_reset(2);
        wt(8);
        state_is(rih_pkg::ST_ERROR);
        plc.hold_reset(RST_CYC + 4);
        wt(6);
        state_is(rih_pkg::ST_IDLE);
        chk("error held", 32'h1, {31'h0, error_o});
        plc.pulse_home();
        wt(6);
        apb(1'b1, `RIH_ADDR_CTRL, 32'h10);
        wt(2);
        chk("err/rdy", 32'h1, {30'h0, error_o, ready_o});
        $display("test error done");
        // Emergency loop
        apb(1'b1, `RIH_ADDR_CTRL, 32'h20);
        wt(2);
        chk("heater", 32'h1, {31'h0, heater_on});
        plc.set_lines(1'b0, 1'b0, 5'h00);
        wt(8);
        chk("estop outs", 32'h0, {24'h0, heater_on, aux_out});
        state_is(rih_pkg::ST_ESTOP);
        plc.hold_reset(RST_CYC + 4);
        wt(6);
        state_is(rih_pkg::ST_ESTOP);
        plc.set_lines(1'b1, 1'b0, 5'h00);
        wt(8);
        state_is(rih_pkg::ST_ESTOP);
        plc.hold_reset(RST_CYC + 4);
        wt(6);
        state_is(rih_pkg::ST_IDLE);
        $display("test estop done");
        print_verdict();
    end
endmodule
`default_nettype wire
